//--- verification/dal_probe_model.sv
/*
 Behavioural debug probe: clocks the two-wire link in frames and
 reports ack, read data and whether the device drove the data pin.
 Assumes the device samples on link clock rises and drives on falls.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dal_regs.svh"

module dal_probe_model (
    // link pins
    output logic      swclk,
    output logic      swdio_in,
    input  wire logic swdio_out,
    input  wire logic swdio_oe
);
    logic drv = 1'b1;
    logic val = 1'b0;
    logic last = 1'b0;
    logic any_oe = 1'b0;

    // no pull on the pin: released, it shows the inverse of the last bit
    assign swdio_in = swdio_oe ? swdio_out : (drv ? val : ~last);

    always @(swdio_oe) if (swdio_oe === 1'b1) any_oe = 1'b1;

    initial swclk = 1'b0;

    // one link period; clock stands low between frames
    task automatic cyc(input logic d, input logic en, output logic s);
        drv = en;
        val = d;
        #62.5 swclk = 1'b1;
        s = swdio_in;
        last = s;
        #62.5 swclk = 1'b0;
    endtask

    task automatic line_reset;
        logic s;
        repeat (52) cyc(1'b1, 1'b1, s);
        repeat (2) cyc(1'b0, 1'b1, s);
    endtask

    task automatic xfer(input logic ap, input logic rd, input logic [1:0] a,
                        input logic [31:0] wd, output logic [2:0] ack,
                        output logic [31:0] rdat, output logic oe_seen);
        logic       s;
        logic [7:0] h;
        h = {1'b1, 1'b0, ^{ap, rd, a}, a[1], a[0], rd, ap, 1'b1};
        rdat = 32'h0;
        any_oe = 1'b0;
        for (int i = 0; i < 8; i++) cyc(h[i], 1'b1, s);
        cyc(1'b0, 1'b0, s);
        for (int i = 0; i < 3; i++) cyc(1'b0, 1'b0, ack[i]);
        // no ack: abandon the frame and resynchronise
        if (ack !== `DAL_ACK_OK) begin
            line_reset();
        end else if (rd) begin
            for (int i = 0; i < 32; i++) cyc(1'b0, 1'b0, rdat[i]);
            cyc(1'b0, 1'b0, s);
            // bad read parity shows up as a failed ack
            if (s !== ^rdat) ack = 3'h0;
            cyc(1'b0, 1'b0, s);
        end else begin
            cyc(1'b0, 1'b0, s);
            for (int i = 0; i < 32; i++) cyc(wd[i], 1'b1, s);
            cyc(^wd, 1'b1, s);
        end
        drv = 1'b1;
        val = 1'b0;
        oe_seen = any_oe;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_dal_access_lock.sv
/*
 Testbench of the debug access lock: probe frames, firmware and flash
 pulses, reset with every protection code.
 Assumes dal_probe_model on the link pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dal_regs.svh"

module tb_dal_access_lock;
    import dal_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h0A5C_0001; // arbitrary value
    localparam logic [31:0] IDLE   = 32'hFFFF_FFFC;
    localparam logic [31:0] CBASE  = 32'h2000_0000;
    localparam int P_OFF = 0, P_ON = 1, P_PROT = 2, P_KILL = 3;
    localparam int P_ERASED = 4, P_CLR = 5;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        swclk, swdio_in, swdio_out, swdio_oe;
    logic [5:0]  pls = 6'h00;
    logic [31:0] cpu_pc = IDLE;
    logic [31:0] cpu_daddr = IDLE;
    logic        cpu_daddr_vld = 1'b0;
    logic [1:0]  nv_prot = 2'h0;
    logic        erase_req, dbg_enabled, port_open, ext_if_off;
    dal_lock_t   lock_state;
    logic [3:0]  bp_hit;
    logic [1:0]  wp_hit;
    int          failures = 0;
    int          tests_run = 0;
    int          n_erase = 0;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (erase_req === 1'b1) n_erase++;

    dal_probe_model prb_u (
        .swclk(swclk), .swdio_in(swdio_in),
        .swdio_out(swdio_out), .swdio_oe(swdio_oe)
    );

    dal_access_lock #(.NUM_BP(4), .NUM_WP(2), .PORT_ID(ID_VAL)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .swclk(swclk),
        .swdio_in(swdio_in), .swdio_out(swdio_out), .swdio_oe(swdio_oe),
        .cpu_dbg_off(pls[P_OFF]), .cpu_dbg_on(pls[P_ON]),
        .cpu_set_prot(pls[P_PROT]), .cpu_set_kill(pls[P_KILL]),
        .cpu_pc(cpu_pc), .cpu_daddr(cpu_daddr),
        .cpu_daddr_vld(cpu_daddr_vld), .nv_prot(nv_prot),
        .erase_done(pls[P_ERASED]), .prot_cleared(pls[P_CLR]),
        .erase_req(erase_req), .lock_state(lock_state),
        .dbg_enabled(dbg_enabled), .port_open(port_open),
        .ext_if_off(ext_if_off), .bp_hit(bp_hit), .wp_hit(wp_hit)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_lock(input dal_lock_t e);
        tests_run++;
        if (lock_state !== e) begin
            failures++;
            $display("mismatch lock_state expected %0d seen %0d", e,
                     lock_state);
        end
    endtask

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic pulse(input int k);
        tick();
        pls[k] = 1'b1;
        tick();
        pls = 6'h00;
        tick();
    endtask

    task automatic rst(input logic [1:0] nv, input dal_lock_t e);
        nv_prot = nv;
        resetn = 1'b0;
        repeat (16) tick();
        resetn = 1'b1;
        repeat (3) tick();
        chk_lock(LK_EVAL);
        chk("port_open", 32'h0, {31'h0, port_open});
        chk("dbg_enabled", 32'h1, {31'h0, dbg_enabled});
        tick();
        chk_lock(e);
        chk("ext_if_off", {31'h0, e == LK_KILL}, {31'h0, ext_if_off});
        chk("port_open", {31'h0, e == LK_OPEN}, {31'h0, port_open});
    endtask

    // refused frames must leave the pin undriven throughout
    task automatic acc(input logic ap, input logic rnw, input logic [1:0] a,
                       input logic [31:0] d, input logic ok,
                       input logic [31:0] e);
        logic [2:0]  ack;
        logic [31:0] rdat;
        logic        oe_seen;
        prb_u.xfer(ap, rnw, a, d, ack, rdat, oe_seen);
        chk("pin driven", {31'h0, ok}, {31'h0, oe_seen});
        if (ok) begin
            chk("ack", {29'h0, `DAL_ACK_OK}, {29'h0, ack});
            if (rnw) chk("read data", e, rdat);
        end
    endtask

    task automatic chk_dbg(input logic e);
        chk("dbg_enabled", {31'h0, e}, {31'h0, dbg_enabled});
    endtask

    initial begin
        rst(2'h1, LK_PROT);
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b0, 32'h0);
        rst(2'h2, LK_KILL);
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b0, 32'h0);
        rst(2'h3, LK_OPEN);
        rst(2'h0, LK_OPEN);
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b1, ID_VAL);
        acc(1'b0, 1'b1, `DAL_DP_STAT, 32'h0, 1'b1, 32'h3);
        acc(1'b1, 1'b0, `DAL_AP_EN, 32'h3F, 1'b1, 32'h0);
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, 1'b0, `DAL_AP_SEL, 32'(i), 1'b1, 32'h0);
            acc(1'b1, 1'b0, `DAL_AP_CMP, CBASE + 32'(4 * i), 1'b1, 32'h0);
        end
        acc(1'b1, 1'b1, `DAL_AP_SEL, 32'h0, 1'b1, 32'h5);
        acc(1'b1, 1'b1, `DAL_AP_CMP, 32'h0, 1'b1, CBASE + 32'h14);
        acc(1'b1, 1'b1, `DAL_AP_EN, 32'h0, 1'b1, 32'h3F);
        for (int i = 0; i < 6; i++) begin
            tick();
            if (i < 4) cpu_pc = CBASE + 32'(4 * i);
            else cpu_daddr = CBASE + 32'(4 * i);
            cpu_daddr_vld = 1'b1;
            tick();
            chk("hits", 32'h1 << i, {26'h0, wp_hit, bp_hit});
            cpu_pc = IDLE;
            cpu_daddr = IDLE;
            repeat (2) tick();
        end
        acc(1'b0, 1'b0, `DAL_DP_ERASE, `DAL_ERASE_KEY, 1'b1, 32'h0);
        chk("erase pulses", 32'h1, 32'(n_erase));
        pulse(P_OFF);
        chk_dbg(1'b0);
        chk("port_open", 32'h0, {31'h0, port_open});
        cpu_pc = CBASE;
        repeat (2) tick();
        chk("bp_hit", 32'h0, {28'h0, bp_hit});
        cpu_pc = IDLE;
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b0, 32'h0);
        pulse(P_ON);
        chk_dbg(1'b0);
        pulse(P_CLR);
        pulse(P_ON);
        chk_dbg(1'b0);
        pulse(P_ERASED);
        pulse(P_CLR);
        pulse(P_ON);
        chk_dbg(1'b1);
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b1, ID_VAL);
        pulse(P_PROT);
        chk_lock(LK_PROT);
        acc(1'b0, 1'b1, `DAL_DP_ID, 32'h0, 1'b0, 32'h0);
        acc(1'b0, 1'b0, `DAL_DP_ERASE, `DAL_ERASE_KEY, 1'b1, 32'h0);
        chk("erase pulses", 32'h2, 32'(n_erase));
        pulse(P_ERASED);
        chk_lock(LK_OPEN);
        pulse(P_KILL);
        chk_lock(LK_KILL);
        chk("ext_if_off", 32'h1, {31'h0, ext_if_off});
        acc(1'b0, 1'b0, `DAL_DP_ERASE, `DAL_ERASE_KEY, 1'b0, 32'h0);
        chk("erase pulses", 32'h2, 32'(n_erase));
        pulse(P_ERASED);
        chk_lock(LK_KILL);
        tally_and_finish();
    end

    // about three times the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verilog/dal_access_lock.sv
/*
 Debug access lock: gates the two-wire debug port by firmware debug
 enable and flash protection state, and holds the breakpoint and
 watchpoint comparators reached through that port.
 Assumes flash, processor and this block share ref_clk; only the probe
 pins are asynchronous.
*/
// Notes on behaviour
// - Debug comes out of reset enabled with no firmware action.
// - Only processor code can switch debug off, never the probe.
// - Debug returns only after full erase, protection clear, then firmware enable.
// - The kill setting shuts every external interface for good.
// - Under kill no programming, debug or test access is answered.
// - When open, the serial port reaches every debug function.
// - The link is two-wire serial, probe drives it by the serial wire protocol.
// - Four address breakpoint and two data watchpoint comparators sit behind the port.
// - A blank part is unprotected with free debug access.
// - Protected blocks debug and returns to open only after full erase; comparators set while open still flag hits while debug stays enabled.
// - Kill blocks all debug and refuses external erase, so it is never left; comparators set while open still flag hits while debug stays enabled.
`timescale 1ns/100ps
`default_nettype none
`include "dal_regs.svh"

module dal_access_lock #(
    parameter int          NUM_BP  = 4,
    parameter int          NUM_WP  = 2,
    parameter logic [31:0] PORT_ID = 32'h0A5C_0001 // arbitrary value
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            resetn,
    // probe pins
    input  wire logic            swclk,
    input  wire logic            swdio_in,
    output logic                 swdio_out,
    output logic                 swdio_oe,
    // processor
    input  wire logic            cpu_dbg_off,
    input  wire logic            cpu_dbg_on,
    input  wire logic            cpu_set_prot,
    input  wire logic            cpu_set_kill,
    input  wire logic [31:0]     cpu_pc,
    input  wire logic [31:0]     cpu_daddr,
    input  wire logic            cpu_daddr_vld,
    // flash
    input  wire logic [1:0]      nv_prot,
    input  wire logic            erase_done,
    input  wire logic            prot_cleared,
    output logic                 erase_req,
    // status
    output var dal_pkg::dal_lock_t lock_state,
    output logic                 dbg_enabled,
    output logic                 port_open,
    output logic                 ext_if_off,
    output logic [NUM_BP-1:0]    bp_hit,
    output logic [NUM_WP-1:0]    wp_hit
);
    import dal_pkg::*;

    localparam int NCMP   = NUM_BP + NUM_WP;
    localparam int EV_MAX = `DAL_EVAL_CYCLES + 1;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic             rise;
    logic             fall;
    logic             bit_v;
    logic             line_rst;
    dal_lock_t        lock_q;
    logic [2:0]       eval_q;
    logic             dbg_en_q;
    dal_rcv_t         rcv_q;
    dal_link_t        link_q;
    logic [7:0]       hdr_sh;
    logic [2:0]       hcnt;
    logic [5:0]       rcnt;
    logic [5:0]       fcnt;
    logic             apndp_q;
    logic             rnw_q;
    logic [1:0]       a_q;
    logic [35:0]      tx_sh;
    logic [32:0]      wd_sh;
    logic [2:0]       sel_q;
    logic [NCMP-1:0]  cmp_en_q;
    logic [31:0]      cmp_q [NCMP];
    logic [NCMP-1:0]  hit_q;
    wire  [NCMP-1:0]  match;

    dal_swd_phy u_phy (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .swclk    (swclk),
        .swdio_in (swdio_in),
        .rise_stb (rise),
        .fall_stb (fall),
        .bit_val  (bit_v),
        .line_rst (line_rst)
    );

    // protection state, read from flash once the checks run out
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lock_q <= LK_EVAL;
            eval_q <= 3'h0;
        end else begin
            case (lock_q)
                LK_EVAL: begin
                    eval_q <= eval_q + 3'h1;
                    if (eval_q == 3'(`DAL_EVAL_CYCLES - 1)) begin
                        if (nv_prot == `DAL_PROT_KILL)
                            lock_q <= LK_KILL;
                        else if (nv_prot == `DAL_PROT_PROT)
                            lock_q <= LK_PROT;
                        else
                            lock_q <= LK_OPEN;
                    end
                end
                LK_OPEN: begin
                    if (cpu_set_kill)
                        lock_q <= LK_KILL;
                    else if (cpu_set_prot)
                        lock_q <= LK_PROT;
                end
                LK_PROT: if (erase_done) lock_q <= LK_OPEN;
                LK_KILL: lock_q <= LK_KILL;
                default: lock_q <= LK_EVAL;
            endcase
        end
    end

    // firmware debug enable and its recovery steps
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dbg_en_q <= 1'b1;
            rcv_q    <= RV_OFF;
        end else if (dbg_en_q) begin
            rcv_q <= RV_OFF;
            if (cpu_dbg_off)
                dbg_en_q <= 1'b0;
        end else if (erase_done) begin
            rcv_q <= RV_ERASED;
        end else begin
            case (rcv_q)
                RV_ERASED:
                    if (prot_cleared && lock_q == LK_OPEN)
                        rcv_q <= RV_CLEARED;
                RV_CLEARED:
                    if (cpu_dbg_on) begin
                        dbg_en_q <= 1'b1;
                        rcv_q    <= RV_OFF;
                    end
                default: rcv_q <= rcv_q;
            endcase
        end
    end

    assign port_open   = (lock_q == LK_OPEN) && dbg_en_q;
    assign ext_if_off  = (lock_q == LK_KILL);
    assign lock_state  = lock_q;
    assign dbg_enabled = dbg_en_q;

    // header: start, apndp, rnw, a2, a3, parity, stop, park
    logic [7:0]  hdr_n;
    logic        hdr_ok;
    logic        erase_hdr;
    logic        take;
    logic [5:0]  rn;
    logic [32:0] wd_n;
    logic        wr_fire;
    logic [31:0] rdata;
    logic        shut_nx;

    assign hdr_n     = {bit_v, hdr_sh[7:1]};
    assign hdr_ok    = hdr_n[0] & ~hdr_n[6] & hdr_n[7]
                     & ((^hdr_n[4:1]) == hdr_n[5]);
    assign erase_hdr = ~hdr_n[1] & ~hdr_n[2]
                     & (hdr_n[4:3] == `DAL_DP_ERASE);
    // locked parts still take the erase command, except under kill
    assign take      = hdr_ok & (port_open | (erase_hdr
                     & (lock_q == LK_OPEN || lock_q == LK_PROT)));
    assign rn        = rcnt + 6'h01;
    assign wd_n      = {bit_v, wd_sh[32:1]};
    assign wr_fire   = (link_q == LN_RESP) && rise && !rnw_q
                     && (rn == `DAL_RSP_END) && !line_rst
                     && ((^wd_n[31:0]) == wd_n[32])
                     && (lock_q != LK_KILL);
    // lock leaves open, or evaluation ends in kill, on this edge: the frame
    // goes with it, so no answer outlives the state that allowed it
    assign shut_nx   = (lock_q == LK_OPEN && (cpu_set_kill || cpu_set_prot))
                     || (lock_q == LK_EVAL && nv_prot == `DAL_PROT_KILL
                         && eval_q == 3'(`DAL_EVAL_CYCLES - 1));

    always_comb begin
        rdata = 32'h0;
        if (!hdr_n[1]) begin
            case (hdr_n[4:3])
                `DAL_DP_ID:   rdata = PORT_ID;
                `DAL_DP_STAT: rdata = {27'h0, rcv_q, lock_q, dbg_en_q};
                default:      rdata = 32'h0;
            endcase
        end else begin
            case (hdr_n[4:3])
                `DAL_AP_SEL: rdata = {29'h0, sel_q};
                `DAL_AP_CMP:
                    if (32'(sel_q) < NCMP)
                        rdata = cmp_q[sel_q];
                `DAL_AP_EN:  rdata = 32'(cmp_en_q);
                default:     rdata = 32'(hit_q);
            endcase
        end
    end

    // frame sequencing on link clock rises
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            link_q  <= LN_IDLE;
            hdr_sh  <= 8'h00;
            hcnt    <= 3'h0;
            rcnt    <= 6'h00;
            apndp_q <= 1'b0;
            rnw_q   <= 1'b0;
            a_q     <= 2'h0;
            wd_sh   <= 33'h0;
        end else if (line_rst || lock_q == LK_KILL || shut_nx) begin
            link_q <= LN_IDLE;
        end else begin
            case (link_q)
                LN_IDLE:
                    if (rise && bit_v) begin
                        hdr_sh <= hdr_n;
                        hcnt   <= 3'h1;
                        link_q <= LN_HDR;
                    end
                LN_HDR:
                    if (rise) begin
                        hdr_sh <= hdr_n;
                        hcnt   <= hcnt + 3'h1;
                        if (hcnt == 3'h7) begin
                            link_q  <= take ? LN_RESP : LN_IDLE;
                            rcnt    <= 6'h00;
                            apndp_q <= hdr_n[1];
                            rnw_q   <= hdr_n[2];
                            a_q     <= hdr_n[4:3];
                        end
                    end
                LN_RESP:
                    if (rise) begin
                        rcnt <= rn;
                        if (rn >= `DAL_WD_FIRST)
                            wd_sh <= wd_n;
                        if (rn == `DAL_RSP_END)
                            link_q <= LN_IDLE;
                    end
                default: link_q <= LN_IDLE;
            endcase
        end
    end

    // device drives on link clock falls so the probe samples on rises
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            swdio_out <= 1'b0;
            swdio_oe  <= 1'b0;
            fcnt      <= 6'h00;
            tx_sh     <= 36'h0;
        end else if (link_q == LN_HDR && rise && hcnt == 3'h7 && take) begin
            tx_sh    <= {^rdata, rdata, `DAL_ACK_OK};
            fcnt     <= 6'h00;
            swdio_oe <= 1'b0;
        end else if (link_q != LN_RESP || line_rst || lock_q == LK_KILL
                     || shut_nx) begin
            swdio_oe <= 1'b0;
        end else if (fall) begin
            fcnt <= fcnt + 6'h01;
            if (fcnt != 6'h00 && fcnt <= (rnw_q ? `DAL_RD_LAST
                                                : `DAL_WR_LAST)) begin
                swdio_oe  <= 1'b1;
                swdio_out <= tx_sh[0];
                tx_sh     <= {1'b0, tx_sh[35:1]};
            end else begin
                swdio_oe <= 1'b0;
            end
        end
    end

    // probe erase command
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            erase_req <= 1'b0;
        else
            erase_req <= wr_fire && !apndp_q && a_q == `DAL_DP_ERASE
                      && wd_n[31:0] == `DAL_ERASE_KEY
                      && !cpu_set_kill;
    end

    // comparator set-up through the access port
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_q    <= 3'h0;
            cmp_en_q <= '0;
            for (int i = 0; i < NCMP; i++)
                cmp_q[i] <= 32'h0;
        end else if (wr_fire && apndp_q && port_open) begin
            case (a_q)
                `DAL_AP_SEL: sel_q <= wd_n[2:0];
                `DAL_AP_CMP:
                    if (32'(sel_q) < NCMP)
                        cmp_q[sel_q] <= wd_n[31:0];
                `DAL_AP_EN:  cmp_en_q <= wd_n[NCMP-1:0];
                default:     sel_q <= sel_q;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi++) begin : g_cmp
            if (gi < NUM_BP) begin : g_bp
                assign match[gi] = cmp_en_q[gi] & (cpu_pc == cmp_q[gi]);
            end else begin : g_wp
                assign match[gi] = cmp_en_q[gi] & cpu_daddr_vld
                                 & (cpu_daddr == cmp_q[gi]);
            end
        end
    endgenerate

    // comparators go quiet with debug switched off
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            hit_q <= '0;
        else
            hit_q <= dbg_en_q ? match : '0;
    end

    assign bp_hit = hit_q[NUM_BP-1:0];
    assign wp_hit = hit_q[NCMP-1:NUM_BP];

    property p_dbg_default;
        $rose(resetn) |-> dbg_en_q;
    endproperty
    a_dbg_default: assert property (p_dbg_default)
        else $error("debug not enabled after reset");

    property p_fw_off;
        $fell(dbg_en_q) |-> $past(cpu_dbg_off);
    endproperty
    a_fw_off: assert property (p_fw_off)
        else $error("debug switched off without firmware request");

    property p_reenable;
        $rose(dbg_en_q) |-> $past(rcv_q) == RV_CLEARED && $past(cpu_dbg_on);
    endproperty
    a_reenable: assert property (p_reenable)
        else $error("debug restored outside recovery sequence");

    property p_kill_perm;
        lock_q == LK_KILL |=> lock_q == LK_KILL && ext_if_off;
    endproperty
    a_kill_perm: assert property (p_kill_perm)
        else $error("kill state left");

    property p_kill_silent;
        lock_q == LK_KILL |-> !swdio_oe && !port_open && link_q == LN_IDLE;
    endproperty
    a_kill_silent: assert property (p_kill_silent)
        else $error("port active under kill");

    property p_take;
        link_q == LN_HDR && rise && hcnt == 3'h7 && hdr_ok && port_open
            && !line_rst |=> link_q == LN_RESP;
    endproperty
    a_take: assert property (p_take)
        else $error("valid request refused while open");

    property p_drive_frame;
        swdio_oe |-> link_q == LN_RESP && fcnt >= 6'h02;
    endproperty
    a_drive_frame: assert property (p_drive_frame)
        else $error("pin driven outside a response");

    property p_bp;
        dbg_en_q && match[0] |=> bp_hit[0];
    endproperty
    a_bp: assert property (p_bp)
        else $error("breakpoint match not flagged");

    property p_wp;
        dbg_en_q && match[NUM_BP] |=> wp_hit[0];
    endproperty
    a_wp: assert property (p_wp)
        else $error("watchpoint match not flagged");

    property p_open_default;
        lock_q == LK_EVAL && eval_q == 3'(`DAL_EVAL_CYCLES - 1)
            && nv_prot == `DAL_PROT_OPEN |=> lock_q == LK_OPEN;
    endproperty
    a_open_default: assert property (p_open_default)
        else $error("blank part not opened");

    property p_prot_hold;
        lock_q == LK_PROT && !erase_done |=> lock_q == LK_PROT;
    endproperty
    a_prot_hold: assert property (p_prot_hold)
        else $error("protection left without erase");

    property p_prot_erase_only;
        swdio_oe && lock_q == LK_PROT |-> !apndp_q && !rnw_q
            && a_q == `DAL_DP_ERASE;
    endproperty
    a_prot_erase_only: assert property (p_prot_erase_only)
        else $error("debug access answered while protected");

    property p_kill_no_erase;
        lock_q == LK_KILL && $past(lock_q) == LK_KILL |-> !erase_req;
    endproperty
    a_kill_no_erase: assert property (p_kill_no_erase)
        else $error("erase requested under kill");

    property p_eval_len;
        $rose(resetn) |-> !port_open ##[1:EV_MAX] lock_q != LK_EVAL;
    endproperty
    a_eval_len: assert property (p_eval_len)
        else $error("state evaluation too long or port open early");

    c_kill: cover property (lock_q == LK_OPEN ##1 lock_q == LK_KILL);
    c_recover: cover property ($rose(dbg_en_q));
    c_erase: cover property (erase_req && lock_q == LK_PROT);
    c_bp_hit: cover property (|bp_hit);

endmodule
`default_nettype wire

//--- verilog/dal_pkg.sv
/*
 Types of the debug access lock.
 Assumes nothing of its surroundings.
*/
package dal_pkg;

typedef enum logic [1:0] {LK_EVAL, LK_OPEN, LK_PROT, LK_KILL} dal_lock_t;
typedef enum logic [1:0] {LN_IDLE, LN_HDR, LN_RESP} dal_link_t;
typedef enum logic [1:0] {RV_OFF, RV_ERASED, RV_CLEARED} dal_rcv_t;

endpackage

//--- verilog/dal_regs.svh
/*
 Constants of the debug access lock: timing counts, protection codes,
 link frame positions and port register indices.
 Assumes nothing; definitions only.
*/
`ifndef DAL_REGS_SVH
`define DAL_REGS_SVH

// checks after reset before the port may open
`define DAL_EVAL_CYCLES   4
// consecutive high bits that resynchronise the link
`define DAL_LINE_RST_BITS 50

// protection code held in flash
`define DAL_PROT_OPEN     2'h0
`define DAL_PROT_PROT     2'h1
`define DAL_PROT_KILL     2'h2

`define DAL_ACK_OK        3'h1

// debug port (apndp = 0) register indices
`define DAL_DP_ID         2'h0
`define DAL_DP_STAT       2'h1
`define DAL_DP_ERASE      2'h2
// access port (apndp = 1) register indices
`define DAL_AP_SEL        2'h0
`define DAL_AP_CMP        2'h1
`define DAL_AP_EN         2'h2
`define DAL_AP_HIT        2'h3

`define DAL_ERASE_KEY     32'hE5A5_0F0F

// link clock edges counted after the header's park bit
`define DAL_WD_FIRST      6'h06
`define DAL_RSP_END       6'h26
`define DAL_RD_LAST       6'h24
`define DAL_WR_LAST       6'h03

`endif

//--- verilog/dal_swd_phy.sv
/*
 Link front end: synchronises the probe's clock and data pins to ref_clk,
 marks clock edges and spots a line reset.
 Assumes the link clock is far slower than ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dal_regs.svh"

module dal_swd_phy #(
    parameter int LRST = `DAL_LINE_RST_BITS
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // pins
    input  wire logic swclk,
    input  wire logic swdio_in,
    // events
    output logic      rise_stb,
    output logic      fall_stb,
    output logic      bit_val,
    output logic      line_rst
);
    logic       ck_s1_q;
    logic       ck_s2_q;
    logic       ck_s3_q;
    logic       d_s1_q;
    logic       d_s2_q;
    logic [5:0] ones_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            d_s1_q  <= 1'b0;
            d_s2_q  <= 1'b0;
        end else begin
            ck_s1_q <= swclk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            d_s1_q  <= swdio_in;
            d_s2_q  <= d_s1_q;
        end
    end

    assign rise_stb = ck_s2_q & ~ck_s3_q;
    assign fall_stb = ~ck_s2_q & ck_s3_q;
    assign bit_val  = d_s2_q;

    // held from the last counted high bit until a low bit: the rest of
    // a long run keeps the link idle instead of reading as new headers
    assign line_rst = (ones_q == 6'(LRST));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ones_q <= 6'h00;
        end else if (rise_stb) begin
            if (!d_s2_q)
                ones_q <= 6'h00;
            else if (ones_q != 6'(LRST))
                ones_q <= ones_q + 6'h01;
        end
    end

endmodule
`default_nettype wire
